// ===== core/pgm_bank.sv
// Power-good mask registers and output pin trees
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/10ps
module pgm_bank (
   input  wire logic       core_clk_in,
   input  wire logic       rst_in,
   input  wire logic [7:0] reg_addr_in,
   input  wire logic [7:0] reg_wdata_in,
   input  wire logic       reg_wr_in,
   input  wire logic       reg_rd_in,
   output logic [7:0]      reg_rdata_out,
   input  wire logic [5:0] step_pg_in,
   input  wire logic       aux_two_pg_in,
   input  wire logic       sw_a_one_pg_in,
   input  wire logic       enable_input_one_in,
   input  wire logic       enable_input_two_in,
   input  wire logic       enable_input_four_in,
   input  wire logic       enable_input_five_in,
   input  wire logic       ddr_term_pg_in,
   input  wire logic       sw_b_one_pg_in,
   input  wire logic       sw_b_two_pg_in,
   input  wire logic       aux_one_pg_in,
   input  wire logic       aux_three_pg_in,
   input  wire logic       otp_shared_sel_in,
   output logic            status_out_four_out,
   output logic            status_out_two_out
);
   logic [7:0]           four_rail_q;
   logic [7:0]           four_rail_d;
   logic [7:0]           four_misc_q;
   logic [7:0]           four_misc_d;
   logic [7:0]           two_rail_q;
   logic [7:0]           two_rail_d;
   logic [7:0]           rdata_q;
   logic [7:0]           rdata_d;
   logic                 pg_four_q;
   logic                 pg_four_d;
   logic                 pg_two_q;
   logic                 pg_two_d;
   logic [7:0]           rail_src;
   logic [7:0]           misc_src;
   logic                 shared_src;
   logic                 four_rail_good;
   logic                 four_misc_good;
   logic                 two_rail_good;
   pgm_pkg::pgm_shared_type shared_sel;

   // Address compare shared by write and read paths
   function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
      addr_hit = (addr == ofs);
   endfunction

   // Register write path
   always_comb begin
      four_rail_d = four_rail_q;
      four_misc_d = four_misc_q;
      two_rail_d  = two_rail_q;
      if (reg_wr_in) begin
         // RL1 rail mask store
         if (addr_hit(reg_addr_in, pgm_pkg::OFS_FOUR_RAIL)) begin
            four_rail_d = reg_wdata_in;
         end
         // RL3 misc mask store
         if (addr_hit(reg_addr_in, pgm_pkg::OFS_FOUR_MISC)) begin
            four_misc_d = reg_wdata_in;
         end
         // RL6 out-two mask store
         if (addr_hit(reg_addr_in, pgm_pkg::OFS_TWO_RAIL)) begin
            two_rail_d = reg_wdata_in;
         end
      end
   end

   // Register read path, data valid the cycle after the strobe
   always_comb begin
      rdata_d = pgm_pkg::RDATA_IDLE;
      if (reg_rd_in) begin
         if (addr_hit(reg_addr_in, pgm_pkg::OFS_FOUR_RAIL)) begin
            rdata_d = four_rail_q;
         end else if (addr_hit(reg_addr_in, pgm_pkg::OFS_FOUR_MISC)) begin
            rdata_d = four_misc_q;
         end else if (addr_hit(reg_addr_in, pgm_pkg::OFS_TWO_RAIL)) begin
            rdata_d = two_rail_q;
         end else begin
            rdata_d = pgm_pkg::RDATA_IDLE;
         end
      end
   end

   // RL5 shared source picked by configuration
   assign shared_sel = pgm_pkg::pgm_shared_type'(otp_shared_sel_in);
   always_comb begin
      case (shared_sel)
         pgm_pkg::PGM_SHARED_SW_B_TWO: begin
            shared_src = sw_b_two_pg_in;
         end
         pgm_pkg::PGM_SHARED_AUX_ONE: begin
            shared_src = aux_one_pg_in;
         end
         default: begin
            shared_src = aux_one_pg_in;
         end
      endcase
   end

   // Source vectors in mask bit order
   always_comb begin
      rail_src = 8'h00;
      misc_src = 8'h00;
      // RL1 aux two and switch a one
      rail_src[pgm_pkg::BIT_AUX_TWO]  = aux_two_pg_in;
      rail_src[pgm_pkg::BIT_SW_A_ONE] = sw_a_one_pg_in;
      // RL2 step-down rails six to one
      rail_src[pgm_pkg::BIT_STEP_HI:pgm_pkg::BIT_STEP_LO] = step_pg_in;
      // RL3 enable pin states
      misc_src[pgm_pkg::BIT_EN_FIVE] = enable_input_five_in;
      misc_src[pgm_pkg::BIT_EN_FOUR] = enable_input_four_in;
      misc_src[pgm_pkg::BIT_EN_TWO]  = enable_input_two_in;
      misc_src[pgm_pkg::BIT_EN_ONE]  = enable_input_one_in;
      // RL4 termination, switch b one, aux three
      misc_src[pgm_pkg::BIT_DDR_TERM]  = ddr_term_pg_in;
      misc_src[pgm_pkg::BIT_SW_B_ONE]  = sw_b_one_pg_in;
      misc_src[pgm_pkg::BIT_AUX_THREE] = aux_three_pg_in;
      // RL5 shared bit
      misc_src[pgm_pkg::BIT_SHARED] = shared_src;
   end

   pgm_tree u_four_rail (
      .src_in   (rail_src),
      .mask_in  (four_rail_q),
      .good_out (four_rail_good)
   );

   pgm_tree u_four_misc (
      .src_in   (misc_src),
      .mask_in  (four_misc_q),
      .good_out (four_misc_good)
   );

   // RL6 same rail layout for out-two
   pgm_tree u_two_rail (
      .src_in   (rail_src),
      .mask_in  (two_rail_q),
      .good_out (two_rail_good)
   );

   // RL7 combine the unmasked sources per pin
   always_comb begin
      pg_four_d = four_rail_good & four_misc_good;
      pg_two_d  = two_rail_good;
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         four_rail_q <= pgm_pkg::MASK_RESET;
         four_misc_q <= pgm_pkg::MASK_RESET;
         two_rail_q  <= pgm_pkg::MASK_RESET;
         rdata_q     <= pgm_pkg::RDATA_IDLE;
         pg_four_q   <= pgm_pkg::PG_RESET;
         pg_two_q    <= pgm_pkg::PG_RESET;
      end else begin
         four_rail_q <= four_rail_d;
         four_misc_q <= four_misc_d;
         two_rail_q  <= two_rail_d;
         rdata_q     <= rdata_d;
         pg_four_q   <= pg_four_d;
         pg_two_q    <= pg_two_d;
      end
   end

   assign reg_rdata_out       = rdata_q;
   assign status_out_four_out = pg_four_q;
   assign status_out_two_out  = pg_two_q;

   chk_aux_two_bad: assert property ( // RL1
      @(posedge core_clk_in) disable iff (rst_in)
      (!four_rail_q[pgm_pkg::BIT_AUX_TWO] && !aux_two_pg_in) |=> !status_out_four_out)
      else $error("Unmasked aux reg two fault did not drop out four");

   chk_sw_a_bad: assert property ( // RL1
      @(posedge core_clk_in) disable iff (rst_in)
      (!four_rail_q[pgm_pkg::BIT_SW_A_ONE] && !sw_a_one_pg_in) |=> !status_out_four_out)
      else $error("Unmasked switch a one fault did not drop out four");

   chk_rail_write: assert property ( // RL1
      @(posedge core_clk_in) disable iff (rst_in)
      (reg_wr_in && reg_addr_in == pgm_pkg::OFS_FOUR_RAIL) |=> (four_rail_q == $past(reg_wdata_in)))
      else $error("Out four rail mask write not stored");

   chk_step_bad: assert property ( // RL2
      @(posedge core_clk_in) disable iff (rst_in)
      (|(~step_pg_in & ~four_rail_q[5:0])) |=> !status_out_four_out)
      else $error("Unmasked step-down fault did not drop out four");

   chk_enable_bad: assert property ( // RL3
      @(posedge core_clk_in) disable iff (rst_in)
      (|(~{enable_input_five_in, enable_input_four_in, enable_input_two_in, enable_input_one_in}
         & ~four_misc_q[7:4])) |=> !status_out_four_out)
      else $error("Unmasked enable pin low did not drop out four");

   chk_misc_bad: assert property ( // RL4
      @(posedge core_clk_in) disable iff (rst_in)
      (|(~{ddr_term_pg_in, sw_b_one_pg_in, aux_three_pg_in}
         & ~{four_misc_q[3], four_misc_q[1:0]})) |=> !status_out_four_out)
      else $error("Unmasked misc source fault did not drop out four");

   chk_shared_pick: assert property ( // RL5
      @(posedge core_clk_in) disable iff (rst_in)
      (!four_misc_q[2] && !(otp_shared_sel_in ? sw_b_two_pg_in : aux_one_pg_in))
      |=> !status_out_four_out)
      else $error("Unmasked shared source fault did not drop out four");

   chk_two_bad: assert property ( // RL6
      @(posedge core_clk_in) disable iff (rst_in)
      (|(~{aux_two_pg_in, sw_a_one_pg_in, step_pg_in} & ~two_rail_q)) |=> !status_out_two_out)
      else $error("Unmasked rail fault did not drop out two");

   chk_two_read: assert property ( // RL6
      @(posedge core_clk_in) disable iff (rst_in)
      (reg_rd_in && reg_addr_in == pgm_pkg::OFS_TWO_RAIL) |=> (reg_rdata_out == $past(two_rail_q)))
      else $error("Out two mask read returned wrong data");

   chk_four_good: assert property ( // RL7
      @(posedge core_clk_in) disable iff (rst_in)
      ((&({aux_two_pg_in, sw_a_one_pg_in, step_pg_in} | four_rail_q))
       && (&(misc_src | four_misc_q))) |=> status_out_four_out)
      else $error("Out four low although all unmasked sources good");

   chk_two_good: assert property ( // RL7
      @(posedge core_clk_in) disable iff (rst_in)
      (&({aux_two_pg_in, sw_a_one_pg_in, step_pg_in} | two_rail_q)) |=> status_out_two_out)
      else $error("Out two low although all unmasked sources good");
endmodule

// ===== core/pgm_pkg.sv
// Constants for the power-good output mask bank
// Behaviour
// RL1 - Out-four first mask: bit 7 aux reg two, bit 6 switch a one; 1 excludes.
// RL2 - Out-four first mask: bits 5..0 step-down rails six..one; set bit ignores rail.
// RL3 - Out-four second mask: bits 7..4 enable inputs five, four, two, one; 1 ignores.
// RL4 - Out-four second mask: bit 3 termination reg, bit 1 switch b one, bit 0 aux three.
// RL5 - Second mask bit 2 masks shared source; one-time configuration picks which rail.
// RL6 - Out-two first mask uses the same layout as out-four first mask.
// RL7 - Pin result is good only while every unmasked source is good.
package pgm_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;

   // Register offsets
   localparam logic [7:0] OFS_FOUR_RAIL = 8'ha6;
   localparam logic [7:0] OFS_FOUR_MISC = 8'ha7;
   localparam logic [7:0] OFS_TWO_RAIL  = 8'ha8;

   // Values after reset and on unmapped reads
   localparam logic [7:0] MASK_RESET    = 8'h00;
   localparam logic [7:0] RDATA_IDLE    = 8'h00;
   localparam logic       PG_RESET      = 1'b0;

   // Rail mask field positions
   localparam int unsigned BIT_AUX_TWO  = 7;
   localparam int unsigned BIT_SW_A_ONE = 6;
   localparam int unsigned BIT_STEP_HI  = 5;
   localparam int unsigned BIT_STEP_LO  = 0;

   // Misc mask field positions
   localparam int unsigned BIT_EN_FIVE   = 7;
   localparam int unsigned BIT_EN_FOUR   = 6;
   localparam int unsigned BIT_EN_TWO    = 5;
   localparam int unsigned BIT_EN_ONE    = 4;
   localparam int unsigned BIT_DDR_TERM  = 3;
   localparam int unsigned BIT_SHARED    = 2;
   localparam int unsigned BIT_SW_B_ONE  = 1;
   localparam int unsigned BIT_AUX_THREE = 0;

   // Which rail feeds the shared mask bit
   typedef enum logic {
      PGM_SHARED_AUX_ONE   = 1'b0,
      PGM_SHARED_SW_B_TWO  = 1'b1
   } pgm_shared_type;
endpackage

// ===== core/pgm_tree.sv
// Masked power-good AND tree for one mask register
`timescale 1ns/10ps
module pgm_tree (
   input  wire logic [7:0] src_in,
   input  wire logic [7:0] mask_in,
   output logic            good_out
);
   logic [7:0] term;

   // Each source passes when good or masked
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_term
         assign term[gi] = src_in[gi] | mask_in[gi];
      end
   endgenerate

   assign good_out = &term;
endmodule

// ===== testbench/pgm_src_model.sv
// Far-side model of the rails and enable pins feeding the mask bank
`timescale 1ns/10ps
module pgm_src_model (
   input  wire logic        core_clk_in,
   input  wire logic [16:0] good_in,
   output logic [16:0]      src_out
);
   // Sources change only at a clock edge, like a registered rail status
   always_ff @(posedge core_clk_in) begin
      src_out <= good_in;
   end
endmodule

// ===== testbench/power_good_output_mask_bank_tb.sv
// Self-checking testbench for the power-good output mask bank
`timescale 1ns/10ps
module power_good_output_mask_bank_tb;
   logic        core_clk_in = 1'b0;
   logic        rst_in      = 1'b1;
   logic [7:0]  addr        = 8'h00;
   logic [7:0]  wdata       = 8'h00;
   logic        wr          = 1'b0;
   logic        rd          = 1'b0;
   logic        sel         = 1'b0;
   logic [16:0] good        = '1;
   logic [16:0] src;
   logic [7:0]  rdata;
   logic        p4;
   logic        p2;
   logic [7:0]  m [3]       = '{8'h00, 8'h00, 8'h00};
   int          mismatches  = 0;
   int          comparisons = 0;
   int          cycles      = 0;

   always #2 core_clk_in = ~core_clk_in;

   pgm_src_model model (.core_clk_in(core_clk_in), .good_in(good), .src_out(src));

   pgm_bank dut (
      .core_clk_in(core_clk_in), .rst_in(rst_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .step_pg_in(src[5:0]),
      .sw_a_one_pg_in(src[6]), .aux_two_pg_in(src[7]), .aux_three_pg_in(src[8]),
      .sw_b_one_pg_in(src[9]), .aux_one_pg_in(src[10]), .ddr_term_pg_in(src[11]),
      .enable_input_one_in(src[12]), .enable_input_two_in(src[13]),
      .enable_input_four_in(src[14]), .enable_input_five_in(src[15]),
      .sw_b_two_pg_in(src[16]), .otp_shared_sel_in(sel),
      .status_out_four_out(p4), .status_out_two_out(p2)
   );

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   always @(posedge core_clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         tally_and_finish();
      end
   end

   task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chk1(input string n, input logic e, input logic g);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %b seen %b", n, e, g);
      end
   endtask

   function automatic logic exp4();
      logic [7:0] mv;
      mv = {good[15:11], sel ? good[16] : good[10], good[9:8]};
      return &(good[7:0] | m[0]) & &(mv | m[1]);
   endfunction

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_in);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge core_clk_in);
      wr <= 1'b0;
      if (a >= 8'ha6 && a <= 8'ha8) begin
         m[a - 8'ha6] = d;
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge core_clk_in);
      rd   <= 1'b1;
      addr <= a;
      @(posedge core_clk_in);
      rd <= 1'b0;
      #1;
      chk8("reg_rdata_out", e, rdata);
      @(posedge core_clk_in);
      #1;
      chk8("reg_rdata_out idle", 8'h00, rdata);
   endtask

   // Source changes are driven at a rising edge
   task automatic set_good(input logic [16:0] v);
      @(posedge core_clk_in);
      good <= v;
   endtask

   task automatic chk_pins();
      repeat (3) @(posedge core_clk_in);
      #1;
      chk1("status_out_four_out", exp4(), p4);
      chk1("status_out_two_out", &(good[7:0] | m[2]), p2);
   endtask

   task automatic bit_case(input int r, input int i);
      int k;
      k = (r == 1) ? ((i == 2) ? (sel ? 16 : 10) : i + 8) : i;
      set_good(~(17'h00001 << k));
      wr_reg(8'ha6 + 8'(r), 8'h00);
      chk_pins();
      wr_reg(8'ha6 + 8'(r), 8'h01 << i);
      chk_pins();
   endtask

   task automatic t_reset_regs();
      for (int r = 0; r < 3; r++) begin
         rd_chk(8'ha6 + 8'(r), 8'h00);
      end
      rd_chk(8'ha9, 8'h00);
      chk_pins();
      wr_reg(8'ha6, 8'h5a);
      wr_reg(8'ha7, 8'hc3);
      wr_reg(8'ha8, 8'h81);
      wr_reg(8'ha9, 8'hff);
      rd_chk(8'ha6, 8'h5a);
      rd_chk(8'ha7, 8'hc3);
      rd_chk(8'ha8, 8'h81);
      rd_chk(8'ha9, 8'h00);
   endtask

   task automatic t_bits();
      for (int r = 0; r < 3; r++) begin
         for (int i = 0; i < 8; i++) begin
            bit_case(r, i);
         end
      end
   endtask

   task automatic t_shared();
      for (int s = 0; s < 2; s++) begin
         @(posedge core_clk_in);
         sel <= s[0];
         @(posedge core_clk_in);
         bit_case(1, 2);
         set_good(~(17'h00001 << (s ? 10 : 16)));
         wr_reg(8'ha7, 8'h00);
         chk_pins();
      end
   endtask

   task automatic t_mixed();
      wr_reg(8'ha6, 8'h0f);
      wr_reg(8'ha8, 8'hf0);
      set_good(17'h1ff70);
      chk_pins();
      set_good(17'h1fff0);
      chk_pins();
      wr_reg(8'ha8, 8'hff);
      chk_pins();
   endtask

   task automatic t_mid_reset();
      wr_reg(8'ha7, 8'hff);
      @(posedge core_clk_in);
      rst_in <= 1'b1;
      repeat (2) @(posedge core_clk_in);
      #1;
      chk1("status_out_four_out", 1'b0, p4);
      @(posedge core_clk_in);
      rst_in <= 1'b0;
      m = '{8'h00, 8'h00, 8'h00};
      for (int r = 0; r < 3; r++) begin
         rd_chk(8'ha6 + 8'(r), 8'h00);
      end
      set_good('1);
      chk_pins();
   endtask

   initial begin
      repeat (12) @(posedge core_clk_in);
      rst_in <= 1'b0;
      t_reset_regs();
      t_bits();
      t_shared();
      t_mixed();
      t_mid_reset();
      tally_and_finish();
   end
endmodule
